// ### rtl/ebrg_pkg.sv
// Constants for the external bus request and grant arbiter
// Contract
// - Idle bus plus request: release buses next cycle; the code releases on the third clock edge, after two sync stages
// - Grant with release; halt unless go mode
// - Go mode: run until external access needed
// - Busy access delays release until after completion
// - Grant allowed between two accesses of instruction
// - Request dropped: ungrant, redrive, resume where halted
// - Arbitration works during boot and reset; the code holds EBRG_OWNED, with no grant, while I_RESET_N is low
// - Hung flag when ready but bus granted; the code also requires the core to be halted
// - On release drop grant, hung, then access; the code does all three on one clock edge
// - Emulator enable selects emulation pins, floats grant
package ebrg_pkg;
    localparam int SYNC_STAGES = 2;
    localparam logic ACTIVE_N = 1'h0;
    localparam logic INACTIVE_N = 1'h1;
    typedef enum logic [1:0] {
        EBRG_OWNED,
        EBRG_WAIT_DONE,
        EBRG_GRANTED
    } ebrg_state_e;
endpackage

// ### rtl/ebrg_sync.sv
// Multi-stage synchroniser for an active-low level
`timescale 1ns/10ps
module ebrg_sync #(
    parameter int STAGES = ebrg_pkg::SYNC_STAGES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_level_n,
    output logic o_level_n
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    always_comb begin
        next_chain = {chain[STAGES-2:0], i_level_n};
    end

    // Settles to inactive so a request cannot appear out of reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chain <= '1;
        end else begin
            chain <= next_chain;
        end
    end

    assign o_level_n = chain[STAGES-1];
endmodule // ebrg_sync

// ### rtl/ebrg_arbiter.sv
// Bus request and grant arbiter between the core and an external master
`timescale 1ns/10ps
module ebrg_arbiter #(
    parameter int SYNC_STAGES = ebrg_pkg::SYNC_STAGES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic i_bus_request_n,
    input wire logic i_emulator_enable,
    input wire logic i_emu_bus_request_n,
    input wire logic i_go_mode,
    input wire logic i_ext_access_active,
    input wire logic i_ext_access_done,
    input wire logic i_ext_access_pending,
    input wire logic i_instr_ready,
    output logic o_bus_grant_n,
    output logic o_bus_grant_oe,
    output logic o_emu_bus_grant_n,
    output logic o_bus_drive_en,
    output logic o_core_halt,
    output logic o_grant_hung_n,
    output logic o_ext_access_go
);
    logic req_norm_n;
    logic req_emu_n;
    logic req;
    ebrg_pkg::ebrg_state_e state;
    ebrg_pkg::ebrg_state_e next_state;
    logic bus_grant_n, next_bus_grant_n;
    logic bus_grant_oe, next_bus_grant_oe;
    logic emu_bus_grant_n, next_emu_bus_grant_n;
    logic bus_drive_en, next_bus_drive_en;
    logic core_halt, next_core_halt;
    logic grant_hung_n, next_grant_hung_n;
    logic ext_access_go, next_ext_access_go;
    logic granted;

    // Both request pins synchronised; only the selected one is used
    ebrg_sync #(.STAGES(SYNC_STAGES)) u_sync_norm (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_level_n(i_bus_request_n),
        .o_level_n(req_norm_n)
    );
    ebrg_sync #(.STAGES(SYNC_STAGES)) u_sync_emu (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_level_n(i_emu_bus_request_n),
        .o_level_n(req_emu_n)
    );

    always_comb begin
        req = ((i_emulator_enable ? req_emu_n : req_norm_n) == ebrg_pkg::ACTIVE_N);
    end

    always_comb begin
        next_state = state;
        case (state)
            ebrg_pkg::EBRG_OWNED: begin
                if (req) begin
                    // An access already under way must finish first
                    if (i_ext_access_active && !i_ext_access_done) begin
                        next_state = ebrg_pkg::EBRG_WAIT_DONE;
                    end else begin
                        next_state = ebrg_pkg::EBRG_GRANTED;
                    end
                end
            end
            ebrg_pkg::EBRG_WAIT_DONE: begin
                if (!req) begin
                    next_state = ebrg_pkg::EBRG_OWNED;
                end else if (i_ext_access_done || !i_ext_access_active) begin
                    next_state = ebrg_pkg::EBRG_GRANTED;
                end
            end
            ebrg_pkg::EBRG_GRANTED: begin
                if (!req) begin
                    next_state = ebrg_pkg::EBRG_OWNED;
                end
            end
            default: begin
                next_state = ebrg_pkg::EBRG_OWNED;
            end
        endcase
    end

    always_comb begin
        granted = (next_state == ebrg_pkg::EBRG_GRANTED);
        next_bus_drive_en = !granted;
        next_bus_grant_n = granted ? ebrg_pkg::ACTIVE_N : ebrg_pkg::INACTIVE_N;
        next_emu_bus_grant_n = next_bus_grant_n;
        // Normal grant pin floats while the emulator owns arbitration
        next_bus_grant_oe = !i_emulator_enable;
        // Go mode keeps running until an external access is needed
        next_core_halt = granted && (!i_go_mode || i_ext_access_pending);
        next_grant_hung_n = (granted && i_instr_ready && next_core_halt) ?
            ebrg_pkg::ACTIVE_N : ebrg_pkg::INACTIVE_N;
        // Held access may start only once the bus is back
        next_ext_access_go = !granted && i_ext_access_pending;
    end

    // Reset loads the state and every output register; no grant is given while I_RESET_N is low
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= ebrg_pkg::EBRG_OWNED;
            bus_grant_n <= ebrg_pkg::INACTIVE_N;
            bus_grant_oe <= 1'h1;
            emu_bus_grant_n <= ebrg_pkg::INACTIVE_N;
            bus_drive_en <= 1'h1;
            core_halt <= 1'h0;
            grant_hung_n <= ebrg_pkg::INACTIVE_N;
            ext_access_go <= 1'h0;
        end else begin
            state <= next_state;
            bus_grant_n <= next_bus_grant_n;
            bus_grant_oe <= next_bus_grant_oe;
            emu_bus_grant_n <= next_emu_bus_grant_n;
            bus_drive_en <= next_bus_drive_en;
            core_halt <= next_core_halt;
            grant_hung_n <= next_grant_hung_n;
            ext_access_go <= next_ext_access_go;
        end
    end

    assign o_bus_grant_n = bus_grant_n;
    assign o_bus_grant_oe = bus_grant_oe;
    assign o_emu_bus_grant_n = emu_bus_grant_n;
    assign o_bus_drive_en = bus_drive_en;
    assign o_core_halt = core_halt;
    assign o_grant_hung_n = grant_hung_n;
    assign o_ext_access_go = ext_access_go;
endmodule // ebrg_arbiter

// ### test/ebrg_checker.sv
// Port-level assertions for the bus request and grant arbiter
`timescale 1ns/10ps
module ebrg_checker #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic I_CORE_CLK, I_RESET_N, i_bus_request_n, i_emulator_enable,
    input wire logic i_emu_bus_request_n, i_go_mode, i_ext_access_active, i_ext_access_done,
    input wire logic i_ext_access_pending, o_bus_grant_n, o_bus_grant_oe, o_emu_bus_grant_n,
    input wire logic o_bus_drive_en, o_core_halt, o_grant_hung_n, o_ext_access_go
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Three samples cover the two sync flops plus the decision register
    sequence s_idle_req;
        (!i_bus_request_n && !i_ext_access_active && !i_emulator_enable)[*3];
    endsequence
    sequence s_released;
        (i_bus_request_n && !i_emulator_enable)[*4];
    endsequence
    property p_grant; s_idle_req |=> !o_bus_grant_n && !o_bus_drive_en; endproperty
    a_grant: assert property (p_grant) else $error("grant late");
    property p_release;
        s_released |-> o_bus_grant_n && o_bus_drive_en && !o_core_halt && o_grant_hung_n;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_halt; $fell(o_bus_grant_n) && !$past(i_go_mode) |-> o_core_halt; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_go; !o_bus_grant_n && !o_core_halt |-> $past(i_go_mode); endproperty
    a_go: assert property (p_go) else $error("runs granted");
    property p_hung; !o_grant_hung_n |-> o_core_halt && !o_bus_drive_en; endproperty
    a_hung: assert property (p_hung) else $error("bad hung");
    property p_busy;
        i_ext_access_active && !i_ext_access_done |=> o_bus_drive_en && o_bus_grant_n;
    endproperty
    a_busy: assert property (p_busy) else $error("grant in access");
    property p_oe; i_emulator_enable[*2] |-> !o_bus_grant_oe; endproperty
    a_oe: assert property (p_oe) else $error("grant driven");
    property p_emu;
        (i_emulator_enable && !i_emu_bus_request_n && !i_ext_access_active)[*3]
            |=> !o_emu_bus_grant_n;
    endproperty
    a_emu: assert property (p_emu) else $error("no emu grant");
    property p_resume;
        $rose(o_bus_grant_n) |-> o_grant_hung_n && o_ext_access_go == $past(i_ext_access_pending);
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume");
endmodule // ebrg_checker

// ### test/ebrg_master.sv
// Outside bus master that requests and returns the bus
`timescale 1ns/10ps
module ebrg_master (
    input wire logic i_clk,
    input wire logic i_want,
    input wire logic i_bus_grant_n,
    output logic o_bus_request_n = 1'h1,
    output logic o_drive = 1'h0
);
    always @(posedge i_clk) begin
        o_bus_request_n <= #1 !i_want;
        o_drive <= #1 i_want && !i_bus_grant_n;
    end
endmodule // ebrg_master

// ### test/ebrg_arbiter_tb.sv
// Self-checking bench for the bus request and grant arbiter
`timescale 1ns/10ps
module ebrg_arbiter_tb;
    logic clk = 0, rst_n = 0, want = 0, emu_en = 0, emu_req_n = 1, go = 0, act = 0, done = 0;
    logic pend = 0, rdy = 0, req_n, gnt_n, oe, emu_gnt_n, drv_en, halt, hung_n, acc_go;
    int errors = 0, n_compared = 0;
    // Rows: go, pending, ready, then expected halt and hung_n
    logic [4:0] rows [4] = '{5'h03, 5'h06, 5'h15, 5'h1E};
    wire grant_pin = oe ? gnt_n : 1'h1;
    always #10 clk = ~clk;
    ebrg_arbiter ebrg_arbiter_i (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .i_bus_request_n(req_n),
        .i_emulator_enable(emu_en), .i_emu_bus_request_n(emu_req_n), .i_go_mode(go),
        .i_ext_access_active(act), .i_ext_access_done(done), .i_ext_access_pending(pend),
        .i_instr_ready(rdy), .o_bus_grant_n(gnt_n), .o_bus_grant_oe(oe),
        .o_emu_bus_grant_n(emu_gnt_n), .o_bus_drive_en(drv_en), .o_core_halt(halt),
        .o_grant_hung_n(hung_n), .o_ext_access_go(acc_go));
    ebrg_master ebrg_master_i (.i_clk(clk), .i_want(want), .i_bus_grant_n(grant_pin),
        .o_bus_request_n(req_n), .o_drive());
    task step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(string n, logic [4:0] e, logic [4:0] s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task finish_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(6);
        rst_n = 1;
        foreach (rows[k]) begin
            {go, pend, rdy} = rows[k][4:2];
            want = 1;
            step(6);
            chk("grant", {3'h0, rows[k][1:0]}, {1'h0, gnt_n, drv_en, halt, hung_n});
            want = 0;
            step(6);
            chk("release", {4'hD, pend}, {gnt_n, drv_en, halt, hung_n, acc_go});
        end
        {go, pend, rdy} = 3'h3;
        act = 1;
        want = 1;
        step(6);
        chk("busy", 5'h03, {gnt_n, drv_en});
        done = 1;
        step(1);
        chk("after_access", 5'h00, {gnt_n, drv_en});
        act = 0;
        done = 0;
        want = 0;
        step(6);
        chk("resume", 5'h1B, {gnt_n, drv_en, halt, hung_n, acc_go});
        emu_en = 1;
        want = 1;
        emu_req_n = 0;
        step(6);
        chk("emu_grant", 5'h00, {oe, emu_gnt_n});
        emu_req_n = 1;
        want = 0;
        step(6);
        chk("emu_release", 5'h06, {emu_gnt_n, drv_en, oe});
        finish_test();
    end
endmodule // ebrg_arbiter_tb
bind ebrg_arbiter ebrg_checker #(.SYNC_STAGES(SYNC_STAGES)) ebrg_checker_i (.*);
